// file: poa_offset_adder.sv
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
// Notes on behaviour
// - Reading moves up or down by any offset in 100 kHz steps.
// - Offset arrives as six BCD digits on twenty-four parallel lines.
// - Offset acts only while the apply line is asserted.
// - Digit, apply and sign lines are all active low.
// - Six digits load straight into the six decade counter presets.
// - Band III leading digits are added serially, one pulse per count of their value.
// - Negative offset adds exactly one 100 kHz pulse per cycle.
// - Sequencer state 0 loads leading digits into the down-counter.
// - State 0 issues load strobe; low sign sets the negative flag.
// - State 1 enables halving of the 2.5 MHz clock.
// - Entering state 1 holds the sequencer and arms the add control.
// - First halved pulse opens the gate; negative adds 100 kHz pulse.
// - Later pulses step 100 MHz decade and down-counter until zero.
// - At zero the add control clears and the hold releases.
module poa_offset_adder
  import poa_pkg::*;
(
  input  wire logic                              SYS_CLK,
  input  wire logic                              SYS_RST,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [11:0]                       PADDR,
  input  wire logic [31:0]                       PWDATA,
  output var  logic [31:0]                       PRDATA,
  output var  logic                              PREADY,
  output var  logic                              PSLVERR,
  input  wire logic [poa_pkg::POA_DIGIT_BITS-1:0] OFFSET_DIGITS_N,
  input  wire logic                              OFFSET_APPLY_N,
  input  wire logic                              OFFSET_MINUS_N,
  input  wire logic                              BAND3_ACTIVE,
  input  wire logic                              SEQ_STATE0,
  input  wire logic                              SEQ_STATE1,
  input  wire logic [poa_pkg::POA_LEAD_BITS-1:0] LEADING_DIGITS,
  output var  logic [poa_pkg::POA_DIGIT_BITS-1:0] PRESET_DIGITS,
  output var  logic                              PRESET_LOAD,
  output var  logic                              SEQ_HOLD,
  output var  logic                              HUNDRED_MHZ_DECADE_GATE,
  output var  logic                              LOW_DECADE_INCREMENT_PULSE,
  output var  logic                              HIGH_DECADE_INCREMENT_PULSE
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [POA_PIN_BITS-1:0] pin_s1_ff;
  logic [POA_PIN_BITS-1:0] pin_s2_ff;
  logic [POA_PIN_BITS-1:0] pin_s3_ff;
  logic [POA_PIN_BITS-1:0] pin_ff;
  logic [POA_PIN_BITS-1:0] pin_agree;
  logic [POA_PIN_BITS-1:0] nxt_pin;

  // Only bits where stages two and three agree may change
  assign pin_agree = ~(pin_s2_ff ^ pin_s3_ff);
  assign nxt_pin   = (pin_s2_ff & pin_agree) | (pin_ff & ~pin_agree);

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      pin_s1_ff <= POA_PINS_RST;
      pin_s2_ff <= POA_PINS_RST;
      pin_s3_ff <= POA_PINS_RST;
      pin_ff    <= POA_PINS_RST;
    end
    else
    begin
      pin_s1_ff <= {OFFSET_MINUS_N, OFFSET_APPLY_N, OFFSET_DIGITS_N};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= nxt_pin;
    end
  end

  wire logic [POA_DIGIT_BITS-1:0] offset_digits = ~pin_ff[POA_DIGIT_BITS-1:0];
  wire logic apply_on = ~pin_ff[POA_DIGIT_BITS];
  wire logic minus_on = ~pin_ff[POA_DIGIT_BITS+1];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        neg_ff;
  logic        hold_ff;
  poa_state_e  state_ff;
  poa_state_e  nxt_state;
  logic [POA_LEAD_BITS-1:0] dc_count;
  logic        dc_zero;

  wire logic access    = PSEL & PENABLE;
  wire logic take      = access & ~pready_ff;
  wire logic commit_wr = access & pready_ff & PWRITE;
  wire logic hit_ctrl  = (PADDR == POA_CTRL_OFF);
  wire logic hit_stat  = (PADDR == POA_STATUS_OFF);
  wire logic hit_cnt   = (PADDR == POA_COUNT_OFF);
  wire logic hit_dig   = (PADDR == POA_DIGITS_OFF);
  wire logic hit_any   = hit_ctrl | hit_stat | hit_cnt | hit_dig;

  wire logic [31:0] status_word = 32'(
    ({5'h0, (state_ff != POA_IDLE)} << POA_ST_BUSY_BIT)
    | ({5'h0, neg_ff}   << POA_ST_NEG_BIT)
    | ({5'h0, hold_ff}  << POA_ST_HOLD_BIT)
    | ({5'h0, dc_zero}  << POA_ST_ZERO_BIT)
    | ({5'h0, apply_on} << POA_ST_APPLY_BIT)
    | ({5'h0, minus_on} << POA_ST_MINUS_BIT));

  wire logic [31:0] rd_mux =
      hit_ctrl ? {30'h0, ctrl_ff}
    : hit_stat ? status_word
    : hit_cnt  ? {20'h0, dc_count}
    : hit_dig  ? {8'h0, offset_digits}
    : 32'h0;

  // One wait state: data and ready both leave flip-flops
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      pready_ff  <= take;
      pslverr_ff <= take & ~hit_any;
      prdata_ff  <= (take & ~PWRITE) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      ctrl_ff <= POA_CTRL_RST;
    else if (commit_wr && hit_ctrl)
      ctrl_ff <= PWDATA[1:0];
  end

  wire logic sw_enable = ctrl_ff[POA_CTRL_ENABLE_BIT];
  wire logic band3     = BAND3_ACTIVE | ctrl_ff[POA_CTRL_BAND3_BIT];

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [6:0] base_cnt_ff;
  logic       half_ff;
  logic       tick_ff;

  // 2.5 MHz base rate as an enable pulse
  wire logic base_tick = (base_cnt_ff == POA_BASE_LAST);
  wire logic half_run  = (state_ff == POA_ARM) | (state_ff == POA_ADD);

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      base_cnt_ff <= 7'h0;
      half_ff     <= 1'b0;
      tick_ff     <= 1'b0;
    end
    else
    begin
      base_cnt_ff <= base_tick ? 7'h0 : base_cnt_ff + 7'h1;
      if (!half_run)
        half_ff <= 1'b0;
      else if (base_tick)
        half_ff <= ~half_ff;
      tick_ff <= half_run & base_tick & half_ff;
    end
  end

  // ----------------------------------------------------------------
  // Offset cycle control
  // ----------------------------------------------------------------
  // apply gate
  wire logic start    = apply_on & sw_enable & SEQ_STATE0;
  wire logic do_load  = (state_ff == POA_IDLE) & start;
  wire logic first_pl = (state_ff == POA_ARM) & tick_ff;
  wire logic step     = (state_ff == POA_ADD) & tick_ff & ~dc_zero;
  wire logic finish   = (state_ff == POA_ADD) & tick_ff & dc_zero;

  // leading digits only in band III
  wire logic [POA_LEAD_BITS-1:0] lead_load = band3 ? LEADING_DIGITS : '0;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      POA_IDLE:
        if (start)
          nxt_state = POA_LOADED;
      POA_LOADED:
        if (SEQ_STATE1)
          nxt_state = POA_ARM;
        else if (!apply_on)
          nxt_state = POA_IDLE;
      POA_ARM:
        if (tick_ff)
          nxt_state = POA_ADD;
      POA_ADD:
        if (finish)
          nxt_state = POA_IDLE;
      default:
        nxt_state = POA_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      state_ff <= POA_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      neg_ff <= 1'b0;
    else if (do_load)
      neg_ff <= minus_on;
    else if (finish)
      neg_ff <= 1'b0;
  end

  poa_down_counter poa_down_counter_inst
  (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .load       (do_load),
    .load_value (lead_load),
    .dec        (step),
    .count      (dc_count),
    .zero       (dc_zero)
  );

  // ----------------------------------------------------------------
  // Outputs to counting chain and sequencer
  // ----------------------------------------------------------------
  logic [POA_DIGIT_BITS-1:0] preset_ff;
  logic preset_load_ff;
  logic gate_ff;
  logic low_pulse_ff;
  logic high_pulse_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      preset_ff      <= '0;
      preset_load_ff <= 1'b0;
      hold_ff        <= 1'b0;
      gate_ff        <= 1'b0;
      low_pulse_ff   <= 1'b0;
      high_pulse_ff  <= 1'b0;
    end
    else
    begin
      preset_load_ff <= do_load;
      if (do_load)
        preset_ff <= offset_digits;
      hold_ff <= (nxt_state == POA_ARM) | (nxt_state == POA_ADD);
      if (first_pl)
        gate_ff <= 1'b1;
      else if (finish)
        gate_ff <= 1'b0;
      low_pulse_ff <= first_pl & neg_ff;
      high_pulse_ff <= step;
    end
  end

  assign PRESET_DIGITS               = preset_ff;
  assign PRESET_LOAD                 = preset_load_ff;
  assign SEQ_HOLD                    = hold_ff;
  assign HUNDRED_MHZ_DECADE_GATE     = gate_ff;
  assign LOW_DECADE_INCREMENT_PULSE  = low_pulse_ff;
  assign HIGH_DECADE_INCREMENT_PULSE = high_pulse_ff;
  assign PRDATA                      = prdata_ff;
  assign PREADY                      = pready_ff;
  assign PSLVERR                     = pslverr_ff;

endmodule
`default_nettype wire

// file: poa_pkg.sv
`default_nettype none
package poa_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] POA_CTRL_OFF   = 12'h000;
  localparam logic [11:0] POA_STATUS_OFF = 12'h004;
  localparam logic [11:0] POA_COUNT_OFF  = 12'h008;
  localparam logic [11:0] POA_DIGITS_OFF = 12'h00c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POA_CTRL_ENABLE_BIT = 0;
  localparam int POA_CTRL_BAND3_BIT  = 1;
  localparam int POA_ST_BUSY_BIT     = 0;
  localparam int POA_ST_NEG_BIT      = 1;
  localparam int POA_ST_HOLD_BIT     = 2;
  localparam int POA_ST_ZERO_BIT     = 3;
  localparam int POA_ST_APPLY_BIT    = 4;
  localparam int POA_ST_MINUS_BIT    = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  POA_CTRL_RST   = 2'h1;
  localparam logic [25:0] POA_PINS_RST   = 26'h3ffffff;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int POA_DIGITS       = 6;
  localparam int POA_DIGIT_BITS   = 4 * POA_DIGITS;
  localparam int POA_LEAD_DIGITS  = 3;
  localparam int POA_LEAD_BITS    = 4 * POA_LEAD_DIGITS;
  localparam int POA_PIN_BITS     = POA_DIGIT_BITS + 2;
  localparam int POA_SYS_CLK_HZ   = 250_000_000;
  localparam int POA_BASE_CLK_HZ  = 2_500_000;
  localparam int POA_BASE_CYCLES  = POA_SYS_CLK_HZ / POA_BASE_CLK_HZ;
  localparam logic [6:0] POA_BASE_LAST = 7'(POA_BASE_CYCLES - 1);

  typedef enum logic [2:0] {
    POA_IDLE,
    POA_LOADED,
    POA_ARM,
    POA_ADD
  } poa_state_e;

endpackage
`default_nettype wire

// file: poa_down_counter.sv
`default_nettype none
module poa_down_counter
  import poa_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     load,
  input  wire logic [POA_LEAD_BITS-1:0] load_value,
  input  wire logic                     dec,
  output var  logic [POA_LEAD_BITS-1:0] count,
  output var  logic                     zero
);

  // ----------------------------------------------------------------
  // Decade arithmetic
  // ----------------------------------------------------------------
  function automatic logic [3:0] bcd_dec(input logic [3:0] d);
    bcd_dec = (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction

  logic [POA_LEAD_BITS-1:0] count_ff;
  logic [POA_LEAD_BITS-1:0] nxt_count;
  logic [POA_LEAD_DIGITS:0] borrow;

  assign borrow[0] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < POA_LEAD_DIGITS; g++)
    begin : g_dec
      assign nxt_count[4*g +: 4] = borrow[g] ?
        bcd_dec(count_ff[4*g +: 4]) : count_ff[4*g +: 4];
      assign borrow[g+1] = borrow[g] & (count_ff[4*g +: 4] == 4'h0);
    end
  endgenerate

  // Decrement never wraps below zero
  always_ff @(posedge clk)
  begin
    if (rst)
      count_ff <= '0;
    else if (load)
      count_ff <= load_value;
    else if (dec && count_ff != '0)
      count_ff <= nxt_count;
  end

  assign count = count_ff;
  assign zero  = (count_ff == '0);

endmodule
`default_nettype wire

// file: poa_offset_adder_properties.sv
`default_nettype none
module poa_oa_chk
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic OFFSET_APPLY_N,
  input wire logic SEQ_STATE0,
  input wire logic SEQ_STATE1,
  input wire logic PRESET_LOAD,
  input wire logic SEQ_HOLD,
  input wire logic HUNDRED_MHZ_DECADE_GATE,
  input wire logic LOW_DECADE_INCREMENT_PULSE,
  input wire logic HIGH_DECADE_INCREMENT_PULSE
);
  // ----------------------------------------
  // Offset cycle checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  chk_load_pulse: assert property (PRESET_LOAD |=> !PRESET_LOAD)
    else $error("load strobe longer than one cycle");
  chk_load_cause: assert property (PRESET_LOAD |-> $past(SEQ_STATE0))
    else $error("load strobe without state0");
  chk_no_apply: assert property (OFFSET_APPLY_N [*8] |-> !PRESET_LOAD)
    else $error("load strobe while apply is off");
  chk_hold_entry: assert property ($rose(SEQ_HOLD) |-> $past(SEQ_STATE1))
    else $error("hold rose outside state1");
  chk_gate_open: assert property ($rose(SEQ_HOLD) |->
    ##[1:400] $rose(HUNDRED_MHZ_DECADE_GATE))
    else $error("gate did not open after hold");
  chk_low_pulse: assert property (LOW_DECADE_INCREMENT_PULSE |->
    $rose(HUNDRED_MHZ_DECADE_GATE))
    else $error("low decade pulse away from gate opening");
  chk_high_gate: assert property (HIGH_DECADE_INCREMENT_PULSE |->
    HUNDRED_MHZ_DECADE_GATE && SEQ_HOLD)
    else $error("high decade pulse outside gate");
  chk_high_space: assert property (HIGH_DECADE_INCREMENT_PULSE |=>
    !HIGH_DECADE_INCREMENT_PULSE [*8])
    else $error("high decade pulses too close");
  chk_hold_end: assert property ($fell(HUNDRED_MHZ_DECADE_GATE) |->
    $fell(SEQ_HOLD))
    else $error("gate closed without hold release");
  cov_load: cover property (PRESET_LOAD);
  cov_low: cover property (LOW_DECADE_INCREMENT_PULSE);
  cov_end: cover property ($fell(SEQ_HOLD));
endmodule

bind poa_offset_adder poa_oa_chk chk_inst (.SYS_CLK, .SYS_RST,
  .OFFSET_APPLY_N, .SEQ_STATE0, .SEQ_STATE1, .PRESET_LOAD, .SEQ_HOLD,
  .HUNDRED_MHZ_DECADE_GATE, .LOW_DECADE_INCREMENT_PULSE,
  .HIGH_DECADE_INCREMENT_PULSE);
`default_nettype wire

// file: poa_seq_model.sv
`default_nettype none
module poa_seq_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        hold,
  input  wire logic        hp,
  input  wire logic        lp,
  input  wire logic        ld,
  input  wire logic        gt,
  output var  logic        s0,
  output var  logic        s1,
  output var  logic        busy,
  output var  logic [15:0] nh,
  output var  logic [15:0] nl,
  output var  logic [15:0] nld,
  output var  logic [15:0] ng
);
  // ----------------------------------------
  // Sequencer and counting chain
  // ----------------------------------------
  logic [3:0] cnt;
  logic       gt_q;
  assign busy = s0 | s1;
  always_ff @(posedge clk)
  begin
    if (rst | go)
    begin
      s0 <= go;
      s1 <= 1'b0;
      cnt <= 4'h0;
      nh <= 16'h0;
      nl <= 16'h0;
      nld <= 16'h0;
      ng <= 16'h0;
      gt_q <= 1'b0;
    end
    else
    begin
      nh <= nh + 16'(hp);
      nl <= nl + 16'(lp);
      nld <= nld + 16'(ld);
      // Count gate openings, one per offset cycle
      ng <= ng + 16'(gt & ~gt_q);
      gt_q <= gt;
      s0 <= 1'b0;
      if (s0)
        s1 <= 1'b1;
      if (s1 && cnt != 4'hf)
        cnt <= cnt + 4'h1;
      if (s1 && !hold && cnt >= 4'h8)
        s1 <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: poa_offset_adder_tb_top.sv
`default_nettype none
module poa_offset_adder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import poa_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        apply_n, minus_n, band3, s0, s1, pload, hold, gate;
  logic        lowp, highp, go, busy;
  logic [11:0] paddr, lead;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] dig_n, preset;
  logic [15:0] nh, nl, nld, ng;
  int          failures, cmp_count;

  poa_offset_adder poa_offset_adder_inst (.SYS_CLK(clk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OFFSET_DIGITS_N(dig_n), .OFFSET_APPLY_N(apply_n),
    .OFFSET_MINUS_N(minus_n), .BAND3_ACTIVE(band3), .SEQ_STATE0(s0),
    .SEQ_STATE1(s1), .LEADING_DIGITS(lead), .PRESET_DIGITS(preset),
    .PRESET_LOAD(pload), .SEQ_HOLD(hold), .HUNDRED_MHZ_DECADE_GATE(gate),
    .LOW_DECADE_INCREMENT_PULSE(lowp),
    .HIGH_DECADE_INCREMENT_PULSE(highp));
  poa_seq_model poa_seq_model_inst (.clk(clk), .rst(rst), .go(go),
    .hold(hold), .hp(highp), .lp(lowp), .ld(pload), .s0(s0), .s1(s1),
    .busy(busy), .nh(nh), .nl(nl), .nld(nld), .gt(gate),
    .ng(ng));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    @(posedge clk);
    while (pready !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 50)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pins pass a synchroniser, so settle them before the cycle starts
  task automatic run(input logic [11:0] l);
    int i;
    lead <= l;
    repeat (8) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    i = 0;
    while (busy && i < 8000)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 8000)
      failures++;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("preset", 32'h0, 32'(preset));
    chk("hold", 32'h0, 32'(hold));
    apb(1'b0, POA_CTRL_OFF, 32'h0);
    chk("ctrl", 32'(POA_CTRL_RST), rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic t_pos();
    apply_n <= 1'b0;
    dig_n <= ~24'h123456;
    run(12'h003);
    chk("preset", 32'h123456, 32'(preset));
    chk("loads", 32'h1, 32'(nld));
    chk("high", 32'h3, 32'(nh));
    chk("low", 32'h0, 32'(nl));
    chk("hold", 32'h0, 32'(hold));
    chk("gate", 32'h0, 32'(gate));
    chk("gates", 32'h1, 32'(ng));
    apb(1'b0, POA_DIGITS_OFF, 32'h0);
    chk("digits", 32'h00123456, rd);
    apb(1'b0, POA_STATUS_OFF, 32'h0);
    chk("status", 32'((1 << POA_ST_APPLY_BIT) |
        (1 << POA_ST_ZERO_BIT)), rd);
  endtask

  task automatic t_neg();
    minus_n <= 1'b0;
    dig_n <= ~24'h999987;
    run(12'h010);
    chk("preset", 32'h999987, 32'(preset));
    chk("low", 32'h1, 32'(nl));
    chk("high", 32'h0000000a, 32'(nh));
    chk("gates", 32'h1, 32'(ng));
    apb(1'b0, POA_COUNT_OFF, 32'h0);
    chk("count", 32'h0, rd);
  endtask

  task automatic t_off();
    apply_n <= 1'b1;
    run(12'h002);
    chk("loads", 32'h0, 32'(nld));
    chk("high", 32'h0, 32'(nh));
    chk("low", 32'h0, 32'(nl));
    chk("gates", 32'h0, 32'(ng));
    chk("preset", 32'h999987, 32'(preset));
  endtask

  task automatic t_ctrl();
    apply_n <= 1'b0;
    minus_n <= 1'b1;
    apb(1'b1, POA_CTRL_OFF, 32'h0);
    run(12'h001);
    chk("loads", 32'h0, 32'(nld));
    band3 <= 1'b0;
    apb(1'b1, POA_CTRL_OFF, 32'h3);
    run(12'h002);
    chk("high", 32'h2, 32'(nh));
    apb(1'b1, POA_CTRL_OFF, 32'h1);
    run(12'h002);
    chk("high", 32'h0, 32'(nh));
    chk("loads", 32'h1, 32'(nld));
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Longest cycle runs about 2400 clocks; allow ample margin
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial
  begin
    {rst, band3} = 2'h3;
    {psel, penable, pwrite, go} = 4'h0;
    {apply_n, minus_n} = 2'h3;
    paddr = 12'h0;
    pwdata = 32'h0;
    lead = 12'h0;
    dig_n = POA_PINS_RST[23:0];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_pos();
    t_neg();
    t_off();
    t_ctrl();
    end_of_test();
  end
endmodule
`default_nettype wire
